/* File: verilog/cac_top.sv */
// module: AXI4-Lite register file, range selection, analog clamp and two alarms
// assumes: sample_data comes from logic on aclk, sample_valid a one-cycle pulse
`timescale 1ns/100ps
module cac_top import cac_pkg::*; #(
   parameter int ADDR_W = 8,
   parameter int BLINK_CYCLES = BLINK_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic sample_valid,
   input wire logic [DW-1:0] sample_data,
   output logic [NALM-1:0] alarm_active,
   output logic [NALM-1:0] relay_drive,
   output logic [1:0] range_id,
   output logic [DW-1:0] analog_code,
   output logic analog_full_scale,
   output logic [DW-1:0] display_value,
   output logic display_blink
);
   typedef enum logic [7:0] {
      RG_NONE = 8'h01,
      RG_CTRL = 8'h02,
      RG_APP = 8'h04,
      RG_STAT = 8'h08,
      RG_SAMP = 8'h10,
      RG_ACK = 8'h20,
      RG_LIM = 8'h40,
      RG_ALM = 8'h80
   } cac_reg_e;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_have;
      logic [ADDR_W-1:0] aw_addr;
      logic w_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [3:0] ctrl;
      logic [5:0] app;
      logic [NRNG-1:0][31:0] lim;
      logic [NRNG-1:0][NALM-1:0][19:0] alm;
      logic [NALM-1:0] ack;
      logic [1:0] cur;
      logic auto_on;
      logic samp_v;
      logic [DW-1:0] sample;
      logic ovr;
      logic [DW-1:0] aout;
      logic afull;
      logic blink;
      logic [31:0] bcnt;
   } cac_top_s;

   if (BLINK_CYCLES < 2 || ADDR_W < 8) begin : g_bad
      $error("cac_top: BLINK_CYCLES must be 2 or more and ADDR_W 8 or more");
   end

   cac_top_s q;
   cac_top_s d;
   logic forced;
   logic all_same;
   logic [1:0] sel_app;
   logic [NAUTO-1:0] elig;
   logic up_ok;
   logic dn_ok;
   logic [1:0] up_idx;
   logic [1:0] dn_idx;
   logic [1:0] first_idx;
   logic [DW-1:0] hi_q;
   logic dn_hit;
   logic cur_ok;
   logic [1:0] nxt;
   logic [DW-1:0] lo_n;
   logic [DW-1:0] hi_n;
   logic [31:0] wval;
   logic [19:0] aval;
   logic [31:0] stat;

   function automatic logic [31:0] cac_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[8*b+:8] = n[8*b+:8];
         end
      end
      return r;
   endfunction

   // misaligned or out-of-window addresses decode to nothing and answer SLVERR
   function automatic cac_reg_e cac_dec(input logic [ADDR_W-1:0] a);
      logic [7:0] lo;
      lo = a[7:0];
      if (a[1:0] != 2'h0 || (a >> 8) != '0) begin
         return RG_NONE;
      end
      if (lo == OFS_CTRL) return RG_CTRL;
      if (lo == OFS_APP) return RG_APP;
      if (lo == OFS_STAT) return RG_STAT;
      if (lo == OFS_SAMP) return RG_SAMP;
      if (lo == OFS_ACK) return RG_ACK;
      if (lo[7:4] == OFS_LIM[7:4]) return RG_LIM;
      if (lo[7:5] == OFS_ALM[7:5]) return RG_ALM;
      return RG_NONE;
   endfunction

   always_comb begin
      // three range applications; any pair that matches names the auto application
      forced = (q.app[1:0] != q.app[3:2]) && (q.app[1:0] != q.app[5:4]) &&
               (q.app[3:2] != q.app[5:4]);
      all_same = (q.app[1:0] == q.app[3:2]) && (q.app[1:0] == q.app[5:4]);
      if (q.app[1:0] == q.app[3:2] || q.app[1:0] == q.app[5:4]) begin
         sel_app = q.app[1:0];
      end else begin
         sel_app = q.app[3:2];
      end
      up_ok = 1'b0;
      dn_ok = 1'b0;
      up_idx = 2'h0;
      dn_idx = 2'h0;
      first_idx = 2'h0;
      for (int i = NAUTO - 1; i >= 0; i--) begin
         elig[i] = q.app[2*i+:2] == sel_app;
         if (elig[i]) begin
            first_idx = 2'(i);
         end
         if (elig[i] && 2'(i) > q.cur) begin
            up_ok = 1'b1;
            up_idx = 2'(i);
         end
      end
      for (int i = 0; i < NAUTO; i++) begin
         if (elig[i] && 2'(i) < q.cur) begin
            dn_ok = 1'b1;
            dn_idx = 2'(i);
         end
      end
      cur_ok = (q.cur < 2'(NAUTO)) && elig[q.cur];
      hi_q = q.lim[q.cur][LIM_HI+:DW];
      // percent compare by products: no divider, exact at the threshold
      dn_hit = 24'(sample_data) * 24'(PCT_FULL) <
               24'(q.lim[dn_idx][LIM_HI+:DW]) * 24'(PCT_DOWN);
   end

   assign stat = {25'h0, alarm_active, q.ovr, forced, q.auto_on, q.cur};

   always_comb begin
      d = q;
      d.ack = '0;
      nxt = q.cur;
      lo_n = '0;
      hi_n = '0;
      wval = cac_merge(32'h0, q.wdata, q.wstrb);
      aval = '0;
      // write response handshake
      if (q.bvalid && bready) begin
         d.bvalid = 1'b0;
      end
      if (awvalid && q.awready) begin
         d.aw_have = 1'b1;
         d.aw_addr = awaddr;
      end
      if (wvalid && q.wready) begin
         d.w_have = 1'b1;
         d.wdata = wdata;
         d.wstrb = wstrb;
      end
      if (q.aw_have && q.w_have && !q.bvalid) begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         case (cac_dec(q.aw_addr))
            RG_CTRL: begin
               wval = cac_merge({28'h0, q.ctrl}, q.wdata, q.wstrb);
               d.ctrl = wval[3:0];
            end
            RG_APP: begin
               wval = cac_merge({26'h0, q.app}, q.wdata, q.wstrb);
               d.app = wval[5:0];
            end
            RG_ACK: begin
               d.ack = wval[NALM-1:0];
            end
            RG_LIM: begin
               d.lim[q.aw_addr[3:2]] = cac_merge(q.lim[q.aw_addr[3:2]], q.wdata, q.wstrb);
            end
            RG_ALM: begin
               wval = cac_merge({12'h0, q.alm[q.aw_addr[4:3]][q.aw_addr[2]]}, q.wdata, q.wstrb);
               aval = wval[19:0];
               for (int r = 0; r < NRNG; r++) begin
                  if (q.ctrl[CTRL_SHARED] || all_same || 2'(r) == q.aw_addr[4:3]) begin
                     d.alm[r][q.aw_addr[2]] = aval;
                  end
               end
            end
            RG_STAT, RG_SAMP: begin
               d.bresp = RESP_OKAY;
            end
            default: begin
               d.bresp = RESP_SLVERR;
            end
         endcase
      end
      // read channel
      if (q.rvalid && rready) begin
         d.rvalid = 1'b0;
      end
      if (arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         case (cac_dec(araddr))
            RG_CTRL: d.rdata = {28'h0, q.ctrl};
            RG_APP: d.rdata = {26'h0, q.app};
            RG_STAT: d.rdata = stat;
            RG_SAMP: d.rdata = {16'h0, q.sample};
            RG_ACK: d.rdata = 32'h0;
            RG_LIM: d.rdata = q.lim[araddr[3:2]];
            RG_ALM: d.rdata = {12'h0, q.alm[araddr[4:3]][araddr[2]]};
            default: begin
               d.rdata = 32'h0;
               d.rresp = RESP_SLVERR;
            end
         endcase
      end
      // one write and one read outstanding at most
      d.awready = !d.aw_have && !d.bvalid;
      d.wready = !d.w_have && !d.bvalid;
      d.arready = !d.rvalid;
      d.auto_on = q.ctrl[CTRL_AUTO] && !forced;
      d.samp_v = sample_valid;
      if (sample_valid) begin
         d.sample = sample_data;
         if (!q.auto_on) begin
            nxt = q.ctrl[CTRL_SEL+:2];
         end else if (!cur_ok) begin
            nxt = first_idx;
         end else if (up_ok && sample_data >= hi_q) begin
            nxt = up_idx;
         end else if (dn_ok && dn_hit) begin
            nxt = dn_idx;
         end
         lo_n = q.lim[nxt][DW-1:0];
         hi_n = q.lim[nxt][LIM_HI+:DW];
         // range id and output scaling move in the same edge
         d.cur = nxt;
         d.ovr = sample_data > hi_n;
         d.afull = sample_data >= hi_n;
         if (sample_data >= hi_n) begin
            d.aout = hi_n - lo_n;
         end else if (sample_data <= lo_n) begin
            d.aout = '0;
         end else begin
            d.aout = sample_data - lo_n;
         end
      end
      if (!q.ovr) begin
         d.blink = 1'b0;
         d.bcnt = '0;
      end else if (q.bcnt == 32'(BLINK_CYCLES - 1)) begin
         d.bcnt = '0;
         d.blink = !q.blink;
      end else begin
         d.bcnt = q.bcnt + 32'h1;
      end
      if (!aresetn) begin
         d = '0;
         d.ctrl = CTRL_RST;
         d.app = APP_RST;
         for (int r = 0; r < NRNG; r++) begin
            d.lim[r] = {LIM_HI_RST[r], LIM_LO_RST};
            for (int k = 0; k < NALM; k++) begin
               d.alm[r][k] = ALM_RST;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      q <= d;
   end

   for (genvar k = 0; k < NALM; k++) begin : g_alm
      cac_alarm_if bus ();
      assign bus.sample_valid = q.samp_v;
      assign bus.sample = q.sample;
      assign bus.cfg = cac_alm_cfg_s'(q.alm[q.cur][k]);
      assign bus.ack = q.ack[k];
      cac_alarm_chan cac_alarm_chan_i (
         .aclk(aclk),
         .aresetn(aresetn),
         .a(bus.chan)
      );
      assign alarm_active[k] = bus.active;
      assign relay_drive[k] = bus.relay;
   end

   assign awready = q.awready;
   assign wready = q.wready;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign arready = q.arready;
   assign rvalid = q.rvalid;
   assign rdata = q.rdata;
   assign rresp = q.rresp;
   assign range_id = q.cur;
   assign analog_code = q.aout;
   assign analog_full_scale = q.afull;
   assign display_value = q.sample;
   assign display_blink = q.blink;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_forced;
      forced |=> !q.auto_on;
   endproperty
   a_forced: assert property (p_forced) else $error("auto ranging without shared application");
   property p_up;
      sample_valid && q.auto_on && cur_ok && up_ok && sample_data >= hi_q
         |=> q.cur == $past(up_idx);
   endproperty
   a_up: assert property (p_up) else $error("no step up at upper limit");
   property p_dn;
      sample_valid && q.auto_on && cur_ok && !(up_ok && sample_data >= hi_q) && dn_ok && dn_hit
         |=> q.cur == $past(dn_idx);
   endproperty
   a_dn: assert property (p_dn) else $error("no step down below threshold");
   property p_clamp;
      // judged at the sample: later limit writes only act on the next sample
      sample_valid && sample_data >= hi_n
         |=> q.afull && q.aout == $past(hi_n) - $past(lo_n);
   endproperty
   a_clamp: assert property (p_clamp) else $error("analog output not at full scale");
   property p_disp;
      sample_valid |=> display_value == $past(sample_data);
   endproperty
   a_disp: assert property (p_disp) else $error("display value altered");
   property p_blink;
      q.ovr && q.bcnt == 32'(BLINK_CYCLES - 1) |=> display_blink != $past(display_blink);
   endproperty
   a_blink: assert property (p_blink) else $error("over-range blink did not toggle");
   property p_c_up;
      sample_valid && q.auto_on ##1 q.cur != $past(q.cur);
   endproperty
   c_up: cover property (p_c_up);
   property p_c_blink;
      q.ovr ##1 display_blink;
   endproperty
   c_blink: cover property (p_c_blink);
endmodule // cac_top

/* File: shared/cac_pkg.sv */
// package: constants, register map and alarm setting layout for the alarm/range block
// assumes: one 50 MHz clock, registers reached over AXI4-Lite
package cac_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int BLINK_MS = 250;
   localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
   localparam int DW = 16;
   localparam int NRNG = 4;
   localparam int NAUTO = 3;
   localparam int NALM = 2;
   localparam int PCT_DOWN = 85;
   localparam int PCT_FULL = 100;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_APP = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_SAMP = 8'h0C;
   localparam logic [7:0] OFS_ACK = 8'h10;
   localparam logic [7:0] OFS_LIM = 8'h20;
   localparam logic [7:0] OFS_ALM = 8'h40;
   localparam int CTRL_AUTO = 0;
   localparam int CTRL_SEL = 1;
   localparam int CTRL_SHARED = 3;
   localparam int LIM_HI = 16;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [5:0] APP_RST = 6'h24;
   localparam logic [15:0] LIM_LO_RST = 16'h0000;
   localparam logic [NRNG-1:0][15:0] LIM_HI_RST = {16'h2710, 16'h2710, 16'h03E8, 16'h0064};
   localparam logic [19:0] ALM_RST = 20'h00000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // word layout: setpoint in 15:0, rising 16, defeat 17, failsafe 18, latching 19
   typedef struct packed {
      logic latching;
      logic failsafe;
      logic defeat;
      logic rising;
      logic [DW-1:0] setpoint;
   } cac_alm_cfg_s;
endpackage

/* File: shared/cac_alarm_if.sv */
// interface: settings, sample and state between the top and one alarm channel
// assumes: both ends on aclk
`timescale 1ns/100ps
interface cac_alarm_if;
   import cac_pkg::*;
   logic sample_valid;
   logic [DW-1:0] sample;
   cac_alm_cfg_s cfg;
   logic ack;
   logic active;
   logic relay;
   modport ctl (output sample_valid, sample, cfg, ack, input active, relay);
   modport chan (input sample_valid, sample, cfg, ack, output active, relay);
endinterface

/* File: verilog/cac_alarm_chan.sv */
// module: one setpoint alarm with latch, defeat and relay polarity
// assumes: sample_valid is a one-cycle pulse, settings come from registers
`timescale 1ns/100ps
module cac_alarm_chan import cac_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   cac_alarm_if.chan a
);
   typedef struct packed {
      logic active;
      logic relay;
      logic dft_prev;
      logic lat_prev;
   } cac_chan_s;
   cac_chan_s q;
   cac_chan_s d;
   logic cond;
   logic clr;

   always_comb begin
      if (a.cfg.rising) begin
         cond = a.sample > a.cfg.setpoint;
      end else begin
         cond = a.sample < a.cfg.setpoint;
      end
      // a settings toggle acts as reset, so it must be seen as an edge
      clr = a.ack || (q.dft_prev && !a.cfg.defeat) || (!q.lat_prev && a.cfg.latching);
      d = q;
      d.dft_prev = a.cfg.defeat;
      d.lat_prev = a.cfg.latching;
      if (clr) begin
         d.active = 1'b0;
      end
      if (a.sample_valid && !a.cfg.latching && !cond) begin
         d.active = 1'b0;
      end
      // set wins over a clear in the same cycle
      if (a.sample_valid && cond) begin
         d.active = 1'b1;
      end
      if (a.cfg.defeat) begin
         d.active = 1'b0;
      end
      if (a.cfg.failsafe) begin
         d.relay = !d.active;
      end else begin
         d.relay = d.active;
      end
      if (!aresetn) begin
         d = '0;
      end
   end

   always_ff @(posedge aclk) begin
      q <= d;
   end

   assign a.active = q.active;
   assign a.relay = q.relay;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_rise;
      a.sample_valid && a.cfg.rising && !a.cfg.defeat && a.sample > a.cfg.setpoint |=> a.active;
   endproperty
   a_rise: assert property (p_rise) else $error("rising alarm missed");
   property p_fall;
      a.sample_valid && !a.cfg.rising && !a.cfg.defeat && a.sample < a.cfg.setpoint
         |=> a.active;
   endproperty
   a_fall: assert property (p_fall) else $error("falling alarm missed");
   property p_fs;
      a.cfg.failsafe |=> a.relay == !a.active;
   endproperty
   a_fs: assert property (p_fs) else $error("failsafe relay polarity wrong");
   property p_nfs;
      !a.cfg.failsafe |=> a.relay == a.active;
   endproperty
   a_nfs: assert property (p_nfs) else $error("non-failsafe relay polarity wrong");
   property p_latch;
      a.active && a.cfg.latching && !a.cfg.defeat && !clr |=> a.active;
   endproperty
   a_latch: assert property (p_latch) else $error("latched alarm dropped");
   property p_nolat;
      a.sample_valid && !a.cfg.latching && !cond |=> !a.active;
   endproperty
   a_nolat: assert property (p_nolat) else $error("non-latching alarm held");
   property p_dft;
      a.cfg.defeat |=> !a.active;
   endproperty
   a_dft: assert property (p_dft) else $error("defeated alarm active");
   property p_clr;
      clr && !(a.sample_valid && cond) |=> !a.active;
   endproperty
   a_clr: assert property (p_clr) else $error("latch not cleared");
   property p_c_latch;
      a.active && a.cfg.latching ##1 clr ##1 !a.active;
   endproperty
   c_latch: cover property (p_c_latch);
endmodule // cac_alarm_chan

/* File: verif/cac_panel_model.sv */
// panel and relay side model: coils follow the relay drive, blinking is remembered
// assumes: watches the block's outputs on aclk, clr pulses from the bench
`timescale 1ns/100ps
module cac_panel_model import cac_pkg::*; (
   input wire logic aclk,
   input wire logic clr,
   input wire logic [NALM-1:0] relay_drive,
   input wire logic display_blink,
   output logic [NALM-1:0] coil_on,
   output logic blink_seen
);
   // a coil only follows its drive; relay contacts add no logic of their own
   always_ff @(posedge aclk) begin
      coil_on <= relay_drive;
      if (clr) begin
         blink_seen <= 1'b0;
      end else if (display_blink) begin
         blink_seen <= 1'b1;
      end
   end
endmodule // cac_panel_model

/* File: verif/cac_top_tb.sv */
// testbench: register bus, manual and auto ranging, alarm modes of the alarm/range block
// assumes: cac_top with a short blink period, panel model on the outputs
`timescale 1ns/100ps
module cac_top_tb import cac_pkg::*;;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, full, blink, seen, clr = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp, rid, act, rel, coil;
   logic sample_valid = 0;
   logic [15:0] sample_data = 16'h0, acode, disp;
   int num_errors = 0, total_checks = 0;
   always #10 aclk = ~aclk;
   cac_top #(.ADDR_W(8), .BLINK_CYCLES(4)) cac_top_i (.aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .sample_valid(sample_valid), .sample_data(sample_data), .alarm_active(act),
      .relay_drive(rel), .range_id(rid), .analog_code(acode), .analog_full_scale(full),
      .display_value(disp), .display_blink(blink));
   cac_panel_model cac_panel_model_i (.aclk(aclk), .clr(clr), .relay_drive(rel),
      .display_blink(blink), .coil_on(coil), .blink_seen(seen));
   task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
      total_checks++;
      if (seen_v !== exp_v) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp_v, seen_v);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // write: address and data offered together, each released when taken
   // waits have no limit of their own: only the watchdog ends a hung transfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, wd;
      ad = 0;
      wd = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            ad = 1;
            awvalid <= 0;
         end
         if (wvalid && wready) begin
            wd = 1;
            wvalid <= 0;
         end
      end
      bready <= 1;
      do begin
         @(posedge aclk);
      end while (bvalid !== 1'b1);
      bready <= 0;
      chk("bresp", bresp, er);
   endtask
   task automatic rdr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      araddr <= a;
      arvalid <= 1;
      do begin
         @(posedge aclk);
      end while (arready !== 1'b1);
      arvalid <= 0;
      rready <= 1;
      do begin
         @(posedge aclk);
      end while (rvalid !== 1'b1);
      d = rdata;
      rready <= 0;
      chk("rresp", rresp, er);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rdr(a, RESP_OKAY, rd);
      chk("reg", rd & m, e);
   endtask
   // one sample pulse, then let the range and alarm stages land
   task automatic smp(input logic [15:0] v);
      sample_data <= v;
      sample_valid <= 1;
      @(posedge aclk);
      sample_valid <= 0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic t_reset();
      rdc(OFS_CTRL, 32'hF, 32'h0);
      rdc(OFS_APP, 32'h3F, 32'h24);
      rdc(OFS_LIM, 32'hFFFFFFFF, 32'h00640000);
      rdc(8'h24, 32'hFFFFFFFF, 32'h03E80000);
      rdc(8'h28, 32'hFFFFFFFF, 32'h27100000);
      rdc(8'h2C, 32'hFFFFFFFF, 32'h27100000);
      rdc(OFS_STAT, 32'h1F, 32'h08);
      rdr(8'hFC, RESP_SLVERR, rd);
      chk("unmapped", rd, 32'h0);
      wr(8'hFC, 32'h1, RESP_SLVERR);
   endtask
   task automatic t_manual();
      wr(8'h2C, 32'h01F40064, RESP_OKAY);
      wr(OFS_CTRL, 32'h6, RESP_OKAY);
      smp(16'h012C);
      chk("cal range", {rid, full, acode}, {2'h3, 1'b0, 16'h00C8});
      wr(OFS_CTRL, 32'h2, RESP_OKAY);
      clr <= 1;
      smp(16'h07D0);
      clr <= 0;
      chk("range", rid, 2'h1);
      chk("clamp", {full, acode}, {1'b1, 16'h03E8});
      chk("display", disp, 16'h07D0);
      rdc(OFS_STAT, 32'h1F, 32'h19);
      repeat (12) @(posedge aclk);
      chk("blink", seen, 1'b1);
      smp(16'h0258);
      chk("in range", {full, acode}, {1'b0, 16'h0258});
   endtask
   task automatic t_alarms();
      wr(8'h48, 32'h000101F4, RESP_OKAY);
      wr(8'h4C, 32'h000C012C, RESP_OKAY);
      smp(16'h0258);
      chk("hi trip", {act[0], rel[0], coil[0]}, 3'b111);
      chk("fs idle", rel[1], 1'b1);
      smp(16'h0190);
      chk("hi drop", {act[0], rel[0]}, 2'b00);
      smp(16'h00C8);
      chk("lo trip", {act[1], rel[1]}, 2'b10);
      smp(16'h0190);
      chk("latched", act[1], 1'b1);
      wr(OFS_ACK, 32'h2, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("acked", {act[1], rel[1]}, 2'b01);
      rdc(8'h4C, 32'hFFFFFFFF, 32'h000C012C);
   endtask
   task automatic t_defeat();
      smp(16'h00C8);
      smp(16'h0190);
      wr(8'h4C, 32'h000E012C, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("defeated", act[1], 1'b0);
      wr(8'h4C, 32'h000C012C, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("defeat clr", act[1], 1'b0);
      smp(16'h00C8);
      smp(16'h0190);
      chk("relatched", act[1], 1'b1);
      wr(8'h4C, 32'h0004012C, RESP_OKAY);
      wr(8'h4C, 32'h000C012C, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("latch clr", act[1], 1'b0);
   endtask
   task automatic t_shared();
      wr(OFS_CTRL, 32'hA, RESP_OKAY);
      wr(OFS_ALM, 32'h00010064, RESP_OKAY);
      rdc(8'h48, 32'hFFFFFFFF, 32'h00010064);
      rdc(8'h50, 32'hFFFFFFFF, 32'h00010064);
      // one application on every range copies without the software bit
      wr(OFS_APP, 32'h0, RESP_OKAY);
      wr(OFS_CTRL, 32'h2, RESP_OKAY);
      wr(8'h44, 32'h00020064, RESP_OKAY);
      rdc(8'h54, 32'hFFFFFFFF, 32'h00020064);
      rdc(8'h5C, 32'hFFFFFFFF, 32'h00020064);
   endtask
   task automatic t_auto();
      wr(OFS_APP, 32'h10, RESP_OKAY);
      wr(OFS_CTRL, 32'h1, RESP_OKAY);
      smp(16'h0032);
      chk("lowest", rid, 2'h0);
      rdc(OFS_STAT, 32'h1F, 32'h04);
      smp(16'h0064);
      chk("up", {rid, acode}, {2'h1, 16'h0064});
      smp(16'h1388);
      chk("top", {rid, full, acode}, {2'h1, 1'b1, 16'h03E8});
      smp(16'h0055);
      chk("stay", rid, 2'h1);
      smp(16'h0054);
      chk("down", {rid, acode}, {2'h0, 16'h0054});
      wr(OFS_APP, 32'h24, RESP_OKAY);
      wr(OFS_CTRL, 32'h5, RESP_OKAY);
      smp(16'h0054);
      chk("forced", rid, 2'h2);
      rdc(OFS_STAT, 32'h1F, 32'h0A);
   endtask
   initial begin
      #500us;
      num_errors++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      t_reset();
      t_manual();
      t_alarms();
      t_defeat();
      t_shared();
      t_auto();
      final_report();
   end
endmodule // cac_top_tb
